// file: sim/host_chan_chk.sv
// channel port assertions
// assumes bind onto the design top
`timescale 1ns/10ps
`default_nettype none
module host_chan_chk (
  input wire logic clk, rst, wrStrobe, frameOdd, frameStart, xferDone, tokenValid,
  input wire logic tokenIn, tokenSlow, chanActive,
  input wire logic [3:0] addr, tokenEp,
  input wire logic [31:0] wrData,
  input wire logic [6:0] tokenAddr,
  input wire logic [1:0] tokenType
);
  logic [31:0] cw;
  wire w = wrStrobe && addr == 4'h0;
  always @(posedge clk or posedge rst) begin
    if (rst) cw <= 32'h0;
    else if (w) cw <= wrData;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_tok_addr: assert property (tokenValid |-> tokenAddr == cw[28:22]) else $error("addr");
  a_tok_ep: assert property (tokenValid |-> tokenEp == cw[14:11]) else $error("ep");
  a_tok_kind: assert property (
    tokenValid |-> {tokenType, tokenSlow, tokenIn} == {cw[19:17], cw[15]}) else $error("kind");
  a_parity: assert property (
    tokenValid && cw[18] |-> $past(frameOdd) == cw[29]) else $error("parity");
  a_frame: assert property (tokenValid |-> $past(frameStart)) else $error("frame");
  a_enable: assert property (
    w && wrData[31] && !wrData[30] |-> ##2 chanActive) else $error("on");
  a_stop: assert property (
    w && wrData[30] |-> ##2 (!chanActive && !tokenValid) [*2]) else $error("stop");
  a_done: assert property (xferDone |-> ##2 !chanActive) else $error("done");
endmodule // host_chan_chk
bind host_channel_characteristics host_chan_chk i_chk (.clk, .rst, .wrStrobe, .frameOdd,
  .frameStart, .xferDone, .tokenValid, .tokenIn, .tokenSlow, .chanActive, .addr, .tokenEp,
  .wrData, .tokenAddr, .tokenType);
`default_nettype wire

// file: sim/testbench.sv
// self-checking bench for the channel
// assumes the endpoint model answers tokens
`timescale 1ns/10ps
`default_nettype none
`include "host_chan_consts.vh"
module testbench;
  logic clk = 0, rst = 1, wrStrobe = 0, rdStrobe = 0, frameOdd = 0, frameStart = 0;
  logic xferDone, tokenValid, tokenIn, tokenSlow, chanActive;
  logic [3:0] addr = 4'h0, tokenEp;
  logic [31:0] wrData = 32'h0, rdData, v;
  logic [6:0] tokenAddr;
  logic [1:0] tokenType;
  int err_count = 0, check_count = 0, cyc = 0;
  localparam logic [31:0] CFG = 32'hb686c800;
  host_channel_characteristics #(.TX_LEN(8)) i_dut (.clk, .rst, .addr, .wrData, .wrStrobe,
    .rdStrobe, .rdData, .frameOdd, .frameStart, .xferDone, .tokenValid, .tokenAddr,
    .tokenEp, .tokenIn, .tokenType, .tokenSlow, .chanActive);
  usb_ep_model i_ep (.clk, .rst, .tokenValid, .xferDone);
  initial forever #4 clk = ~clk;
  task automatic chk(input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk) begin addr <= a; wrData <= d; wrStrobe <= 1'b1; end
    @(posedge clk) wrStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk) begin addr <= a; rdStrobe <= 1'b1; end
    @(posedge clk) rdStrobe <= 1'b0;
    #1 v = rdData;
  endtask
  task automatic frm(input logic odd, input logic exp);
    @(posedge clk) begin frameOdd <= odd; frameStart <= 1'b1; end
    @(posedge clk) frameStart <= 1'b0;
    #1 chk(tokenValid, exp);
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin err_count++; give_verdict; end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wr(4'h5, 32'hffffffff);
    rd(4'h5); chk(v, 32'h0);
    wr(4'h0, `CHAR_WMASK);
    rd(4'h0); chk(v & 32'hbfffffff, `CHAR_WMASK & 32'h3fffffff);
    for (int t = 0; t < 4; t++) begin
      wr(4'h0, {CFG[31:20], 2'(t), t[1], CFG[16:16], t[0], CFG[14:0]});
      frm(1'b0, !t[0]);
      if (t[0]) frm(1'b1, 1'b1);
      chk({tokenAddr, tokenEp, tokenIn, tokenType, tokenSlow},
        {7'h5a, 4'h9, t[0], 2'(t), t[1]});
      repeat (12) @(posedge clk);
      rd(4'h0);
      chk(v, {1'b0, CFG[30:20], 2'(t), t[1], CFG[16:16], t[0], CFG[14:0]});
    end
    wr(4'h0, CFG);
    rd(4'h0);
    chk(v, CFG);
    wr(4'h0, CFG | 32'h40000000);
    frm(1'b1, 1'b0);
    rd(4'h0); chk(v[31], 1'b0);
    rd(4'h1);
    chk(v, 32'h00010004);
    give_verdict;
  end
endmodule // testbench
`default_nettype wire

// file: sim/usb_ep_model.sv
// endpoint model ending each transfer
// assumes one clock shared with the channel
`timescale 1ns/10ps
`default_nettype none
module usb_ep_model #(parameter int DLY = 3) (
  input wire logic clk, rst, tokenValid,
  output logic xferDone
);
  int cnt;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      xferDone <= 1'b0;
    end else begin
      xferDone <= (cnt == 1);
      cnt <= tokenValid ? DLY : (cnt > 0 ? cnt - 1 : 0);
    end
  end
endmodule // usb_ep_model
`default_nettype wire

// file: verilog/frame_gate.v
// frame eligibility check for a channel
// assumes frame number parity and type come from the same clock domain
`include "host_chan_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module frame_gate (
  input wire [1:0] xferType,
  input wire parityWanted,
  input wire frameOdd,
  output wire frameOk
);
  // ==========================================
  // periodic types only run in the chosen parity frame
  wire periodic;
  assign periodic = (xferType == `XTYPE_ISO) || (xferType == `XTYPE_INTR);
  assign frameOk = periodic ? (parityWanted == frameOdd) : 1'b1;
endmodule // frame_gate
`default_nettype wire

// file: verilog/host_chan_consts.vh
// constants for the host channel characteristics block
// assumes inclusion by bare name from the design files
`ifndef HOST_CHAN_CONSTS_VH
`define HOST_CHAN_CONSTS_VH
`define CHAR_REG_ADDR 4'h0
`define STAT_REG_ADDR 4'h1
`define BIT_CHAN_ON 31
`define BIT_STOP_REQ 30
`define BIT_PARITY 29
`define DEVADDR_HI 28
`define DEVADDR_LO 22
`define XTYPE_HI 19
`define XTYPE_LO 18
`define BIT_SLOW 17
`define BIT_DIR 15
`define EPIDX_HI 14
`define EPIDX_LO 11
`define MPS_HI 10
`define MPS_LO 0
`define CHAR_RESET 32'h00000000
`define CHAR_WMASK 32'hffceffff
`define XTYPE_CTRL 2'h0
`define XTYPE_ISO 2'h1
`define XTYPE_BULK 2'h2
`define XTYPE_INTR 2'h3
`define TX_CYCLES_NS 64
`define CLK_NS 8
`define TX_CYCLES ((`TX_CYCLES_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// file: verilog/host_channel_characteristics.v
// host channel characteristics register and transaction launcher
// assumes synchronous inputs, one clock, plain register port
//
// Decided for this implementation: the plain strobed port and the register addresses.
`include "host_chan_consts.vh"
`timescale 1ns/10ps
`default_nettype none
module host_channel_characteristics #(
  parameter TX_LEN = `TX_CYCLES
) (
  input wire clk,
  input wire rst,
  input wire [3:0] addr,
  input wire [31:0] wrData,
  input wire wrStrobe,
  input wire rdStrobe,
  output reg [31:0] rdData,
  input wire frameOdd,
  input wire frameStart,
  input wire xferDone,
  output reg tokenValid,
  output reg [6:0] tokenAddr,
  output reg [3:0] tokenEp,
  output reg tokenIn,
  output reg [1:0] tokenType,
  output reg tokenSlow,
  output reg chanActive
);
  // ==========================================
  // state codes
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_BUSY = 3'b100;

  // characteristics word, scheduler state and counters
  reg [31:0] charReg;
  reg [31:0] next_charReg;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] busyCnt;
  reg [7:0] next_busyCnt;
  reg [15:0] tokenCount;
  reg [31:0] next_rdData;
  // decoded strobes and scheduler hand-offs
  wire frameOk;
  wire wrChar;
  wire rdChar;
  wire rdStat;
  wire stopNow;
  wire hwStop;
  wire launch;
  wire [31:0] wrMasked;
  wire [31:0] statusWord;

  function hit;
    input [3:0] a;
    input [3:0] target;
    begin
      hit = (a == target);
    end
  endfunction

  frame_gate gate (
    .xferType(charReg[`XTYPE_HI:`XTYPE_LO]),
    .parityWanted(charReg[`BIT_PARITY]),
    .frameOdd(frameOdd),
    .frameOk(frameOk)
  );

  // ==========================================
  // access decode
  assign wrChar = wrStrobe && hit(addr, `CHAR_REG_ADDR);
  assign rdChar = rdStrobe && hit(addr, `CHAR_REG_ADDR);
  assign rdStat = rdStrobe && hit(addr, `STAT_REG_ADDR);
  // reserved bits are held at reset value whatever is written
  assign wrMasked = wrData & `CHAR_WMASK;
  assign stopNow = wrChar && wrData[`BIT_STOP_REQ];
  // end of transfer or a pending stop drops the enable with no write
  assign hwStop = charReg[`BIT_CHAN_ON] && (xferDone || charReg[`BIT_STOP_REQ]);
  // a token leaves only from the wait state in an eligible frame
  assign launch = (state == ST_WAIT) && (next_state == ST_BUSY);
  assign statusWord = {13'h0, state, tokenCount};

  // ==========================================
  // register file
  // a software write wins over a hardware clear in the same cycle
  always @* begin
    next_charReg = charReg;
    if (wrChar) begin
      next_charReg = wrMasked;
      // stop wins over a set of the enable in the same write
      if (wrData[`BIT_STOP_REQ]) begin
        next_charReg[`BIT_CHAN_ON] = 1'b0;
      end
    end else if (hwStop) begin
      next_charReg[`BIT_CHAN_ON] = 1'b0;
      next_charReg[`BIT_STOP_REQ] = 1'b0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      charReg <= `CHAR_RESET;
    end else begin
      charReg <= next_charReg;
    end
  end

  // ==========================================
  // read port
  // read data holds between reads; unmapped indexes read zero
  always @* begin
    next_rdData = rdData;
    if (rdChar) begin
      next_rdData = charReg;
    end else if (rdStat) begin
      next_rdData = statusWord;
    end else if (rdStrobe) begin
      next_rdData = 32'h00000000;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData <= 32'h00000000;
    end else begin
      rdData <= next_rdData;
    end
  end

  // ==========================================
  // transaction scheduler
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (charReg[`BIT_CHAN_ON] && !stopNow) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!charReg[`BIT_CHAN_ON] || stopNow) begin
          next_state = ST_IDLE;
        end else if (frameStart && frameOk) begin
          next_state = ST_BUSY;
        end
      end
      ST_BUSY: begin
        if (stopNow || !charReg[`BIT_CHAN_ON]) begin
          next_state = ST_IDLE;
        end else if (busyCnt == 8'h00) begin
          next_state = ST_WAIT;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ==========================================
  // busy window
  // one token per window keeps the channel to a single transfer slot
  always @* begin
    next_busyCnt = busyCnt;
    if (launch) begin
      next_busyCnt = TX_LEN[7:0] - 8'h01;
    end else if (state == ST_BUSY && busyCnt != 8'h00) begin
      next_busyCnt = busyCnt - 8'h01;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      busyCnt <= 8'h00;
      tokenCount <= 16'h0000;
      chanActive <= 1'b0;
    end else begin
      state <= next_state;
      busyCnt <= next_busyCnt;
      // enable copy trails the register bit by one cycle
      chanActive <= charReg[`BIT_CHAN_ON];
      if (launch) begin
        tokenCount <= tokenCount + 16'h0001;
      end
    end
  end

  // ==========================================
  // token fields
  // fields are captured at launch and stand until the next token
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tokenValid <= 1'b0;
      tokenAddr <= 7'h00;
      tokenEp <= 4'h0;
      tokenIn <= 1'b0;
      tokenType <= 2'h0;
      tokenSlow <= 1'b0;
    end else begin
      tokenValid <= launch;
      if (launch) begin
        tokenAddr <= charReg[`DEVADDR_HI:`DEVADDR_LO];
        tokenEp <= charReg[`EPIDX_HI:`EPIDX_LO];
        tokenIn <= charReg[`BIT_DIR];
        tokenType <= charReg[`XTYPE_HI:`XTYPE_LO];
        tokenSlow <= charReg[`BIT_SLOW];
      end
    end
  end
endmodule // host_channel_characteristics
`default_nettype wire
